// >>> inc/bapcr_consts.vh
// Constants for the bridge converter control and readout block
`ifndef BAPCR_CONSTS_VH
`define BAPCR_CONSTS_VH

// System clock rate
`define BAPCR_CLK_HZ 20000000
// Output data rates selected by the rate pin
`define BAPCR_RATE_LOW_SPS 10
`define BAPCR_RATE_HIGH_SPS 80
// Conversion periods in system clock cycles
`define BAPCR_LOW_CYCLES (`BAPCR_CLK_HZ / `BAPCR_RATE_LOW_SPS)
`define BAPCR_HIGH_CYCLES (`BAPCR_CLK_HZ / `BAPCR_RATE_HIGH_SPS)
// Serial clock high time that requests standby, in microseconds
`define BAPCR_STANDBY_US 10000
`define BAPCR_STANDBY_CYCLES ((`BAPCR_STANDBY_US * (`BAPCR_CLK_HZ / 1000000)))
// Result format
`define BAPCR_RESULT_W 18
`define BAPCR_FILTER_W 24
`define BAPCR_CODE_POS_FS 18'h1_FFFF
`define BAPCR_CODE_NEG_FS 18'h2_0000
`define BAPCR_CODE_ZERO 18'h0_0000
// Filter values that bound the clip
`define BAPCR_FILT_POS_FS 24'h01_FFFF
`define BAPCR_FILT_NEG_FS 24'hFE_0000
// Number of pins passed through the synchroniser
`define BAPCR_SYNC_W 4

`endif

// >>> hdl/bapcr_sync.v
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module bapcr_sync #(
   parameter WIDTH = 4
) (
   input wire sys_clk_in,
   input wire nrst_in,
   input wire [WIDTH-1:0] async_in,
   input wire [WIDTH-1:0] reset_val_in,
   output wire [WIDTH-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_reg;
         reg stable_reg;
         // First stage feeds only the second
         always @(posedge sys_clk_in) begin
            if (!nrst_in) begin
               meta_reg <= reset_val_in[i];
               stable_reg <= reset_val_in[i];
            end else begin
               meta_reg <= async_in[i];
               stable_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stable_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// >>> hdl/bapcr_top.v
// Pin control, conversion pacing and serial readout of the bridge converter
`timescale 1ns/100ps
`include "bapcr_consts.vh"
`default_nettype none
// What this block does
// - Rate pin low slow rate, high fast
// - Power-off pin low resets conversion logic
// - Fresh result shown by driving line low
// - First rising clock starts data, MSB first
// - One result bit per rising serial clock
// - Serial clock held high requests standby
// - Results are eighteen bits wide
// - Grounded negative input gives non-negative codes
// - Two's complement, clip at full scale codes
// - Extra rising edge forces line high
// - Ground switch closed converting, open otherwise
module bapcr_top #(
   parameter [31:0] LOW_CYCLES = `BAPCR_LOW_CYCLES,
   parameter [31:0] HIGH_CYCLES = `BAPCR_HIGH_CYCLES,
   parameter [31:0] STANDBY_CYCLES = `BAPCR_STANDBY_CYCLES
) (
   input wire sys_clk_in,
   input wire nrst_in,
   input wire rate_select_in,
   input wire power_off_n_in,
   input wire serial_clk_in,
   input wire negative_grounded_in,
   input wire [`BAPCR_FILTER_W-1:0] filter_data_in,
   output reg ready_and_serial_out_out,
   output reg bridge_ground_switch_out,
   output reg bridge_ground_switch_oe_out,
   output reg converting_out
);
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_UPDATE = 4'b0010;
   localparam [3:0] ST_READY = 4'b0100;
   localparam [3:0] ST_SHIFT = 4'b1000;

   wire [`BAPCR_SYNC_W-1:0] pins_sync;
   wire sclk_s;
   wire rate_s;
   wire pwr_n_s;
   wire neg_gnd_s;
   reg sclk_prev_reg;
   wire sclk_rise;
   reg [31:0] conv_cnt_reg;
   reg [31:0] conv_cnt_next;
   reg [31:0] high_cnt_reg;
   reg standby_reg;
   reg conv_done;
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [`BAPCR_RESULT_W-1:0] shift_reg;
   reg [`BAPCR_RESULT_W-1:0] shift_next;
   reg [4:0] bit_cnt_reg;
   reg [4:0] bit_cnt_next;
   reg line_next;
   reg [`BAPCR_RESULT_W-1:0] code;
   wire [31:0] period;
   wire active;

   // Pins cross into the system clock domain
   bapcr_sync #(
      .WIDTH(`BAPCR_SYNC_W)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .async_in({negative_grounded_in, power_off_n_in, rate_select_in, serial_clk_in}),
      .reset_val_in(4'h0),
      .sync_out(pins_sync)
   );
   assign sclk_s = pins_sync[0];
   assign rate_s = pins_sync[1];
   assign pwr_n_s = pins_sync[2];
   assign neg_gnd_s = pins_sync[3];

   // Serial clock edge finder
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_s;
      end
   end
   assign sclk_rise = sclk_s & ~sclk_prev_reg;

   // Conversion runs only when powered and not in standby
   assign active = pwr_n_s & ~standby_reg;
   assign period = rate_s ? HIGH_CYCLES : LOW_CYCLES;

   // Standby request: serial clock held high long enough
   always @(posedge sys_clk_in) begin
      if (!nrst_in || !pwr_n_s || !sclk_s) begin
         high_cnt_reg <= 32'h0000_0000;
         standby_reg <= 1'b0;
      end else if (high_cnt_reg >= STANDBY_CYCLES - 32'h0000_0001) begin
         standby_reg <= 1'b1;
      end else begin
         high_cnt_reg <= high_cnt_reg + 32'h0000_0001;
      end
   end

   // Conversion pacer
   always @* begin
      conv_done = 1'b0;
      conv_cnt_next = conv_cnt_reg + 32'h0000_0001;
      if (!active) begin
         conv_cnt_next = 32'h0000_0000;
      end else if (conv_cnt_reg >= period - 32'h0000_0001) begin
         conv_done = 1'b1;
         conv_cnt_next = 32'h0000_0000;
      end
   end

   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         conv_cnt_reg <= 32'h0000_0000;
      end else begin
         conv_cnt_reg <= conv_cnt_next;
      end
   end

   // Clip filter output to the result code range
   always @* begin
      code = filter_data_in[`BAPCR_RESULT_W-1:0];
      if (!filter_data_in[`BAPCR_FILTER_W-1] &&
            filter_data_in > `BAPCR_FILT_POS_FS) begin
         code = `BAPCR_CODE_POS_FS;
      end else if (filter_data_in[`BAPCR_FILTER_W-1] &&
            filter_data_in < `BAPCR_FILT_NEG_FS) begin
         code = `BAPCR_CODE_NEG_FS;
      end
      if (neg_gnd_s && filter_data_in[`BAPCR_FILTER_W-1]) begin
         code = `BAPCR_CODE_ZERO;
      end
   end

   // Readout state machine
   always @* begin
      state_next = state_reg;
      shift_next = shift_reg;
      bit_cnt_next = bit_cnt_reg;
      line_next = ready_and_serial_out_out;
      case (state_reg)
         ST_IDLE: begin
            line_next = 1'b1;
         end
         ST_UPDATE: begin
            line_next = 1'b0;
            state_next = ST_READY;
         end
         ST_READY: begin
            if (sclk_rise) begin
               line_next = shift_reg[`BAPCR_RESULT_W-1];
               shift_next = {shift_reg[`BAPCR_RESULT_W-2:0], 1'b0};
               bit_cnt_next = 5'h01;
               state_next = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (sclk_rise) begin
               if ({27'h000_0000, bit_cnt_reg} == `BAPCR_RESULT_W) begin
                  line_next = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  line_next = shift_reg[`BAPCR_RESULT_W-1];
                  shift_next = {shift_reg[`BAPCR_RESULT_W-2:0], 1'b0};
                  bit_cnt_next = bit_cnt_reg + 5'h01;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
            line_next = 1'b1;
         end
      endcase
      // New result overwrites any unread one, line pulses high first
      if (conv_done) begin
         shift_next = code;
         bit_cnt_next = 5'h00;
         line_next = 1'b1;
         state_next = ST_UPDATE;
      end
      if (!active) begin
         line_next = 1'b1;
         state_next = ST_IDLE;
         bit_cnt_next = 5'h00;
      end
   end

   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         state_reg <= ST_IDLE;
         shift_reg <= `BAPCR_CODE_ZERO;
         bit_cnt_reg <= 5'h00;
         ready_and_serial_out_out <= 1'b1;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_next;
         ready_and_serial_out_out <= line_next;
      end
   end

   // Low-side bridge switch and conversion status
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         bridge_ground_switch_out <= 1'b0;
         bridge_ground_switch_oe_out <= 1'b0;
         converting_out <= 1'b0;
      end else begin
         bridge_ground_switch_out <= 1'b0;
         bridge_ground_switch_oe_out <= active;
         converting_out <= active;
      end
   end
endmodule
`default_nettype wire

// >>> test/bapcr_top_assertions.sv
// Port checks for the converter readout block
`timescale 1ns/100ps
`default_nettype none
module bapcr_checker #(
   parameter [31:0] STANDBY_CYCLES = 100
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic power_off_n_in,
   input wire logic serial_clk_in,
   input wire logic ready_and_serial_out_out,
   input wire logic bridge_ground_switch_out,
   input wire logic bridge_ground_switch_oe_out,
   input wire logic converting_out
);
   logic [31:0] hi_cnt;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence quiet; (!serial_clk_in)[*6]; endsequence
   sequence off_held; (!power_off_n_in)[*4]; endsequence
   // Cycles the serial clock has stood high
   always_ff @(posedge sys_clk_in)
      if (!nrst_in || !serial_clk_in)
         hi_cnt <= 32'h0000_0000;
      else if (hi_cnt < STANDBY_CYCLES + 32'h0000_000A)
         hi_cnt <= hi_cnt + 32'h0000_0001;
   off_line_a: assert property (off_held |-> ready_and_serial_out_out)
      else $error("line low in power-off");
   off_switch_a: assert property (off_held |-> !bridge_ground_switch_oe_out)
      else $error("switch closed in power-off");
   switch_tracks_a: assert property (bridge_ground_switch_oe_out == converting_out)
      else $error("switch differs from activity");
   switch_low_a: assert property (bridge_ground_switch_oe_out
      |-> !bridge_ground_switch_out)
      else $error("switch not to ground");
   // Switch closes only three samples after the power pin was seen high
   switch_needs_power_a: assert property (bridge_ground_switch_oe_out
      |-> $past(power_off_n_in, 3))
      else $error("switch closed without power");
   standby_entry_a: assert property (hi_cnt >= STANDBY_CYCLES + 32'h0000_0008
      |-> !converting_out)
      else $error("no standby on held clock");
   wake_low_a: assert property ((power_off_n_in && !serial_clk_in)[*6]
      |-> converting_out)
      else $error("not active after release");
   wake_line_a: assert property ($rose(converting_out)
      |-> ready_and_serial_out_out[*8])
      else $error("line low after wake");
   ready_holds_a: assert property (quiet ##0 (!ready_and_serial_out_out
      && converting_out && power_off_n_in) |-> ##[1:2] !ready_and_serial_out_out)
      else $error("ready not held");
endmodule
bind bapcr_top bapcr_checker #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_chk (
   .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .power_off_n_in(power_off_n_in),
   .serial_clk_in(serial_clk_in), .ready_and_serial_out_out(ready_and_serial_out_out),
   .bridge_ground_switch_out(bridge_ground_switch_out),
   .bridge_ground_switch_oe_out(bridge_ground_switch_oe_out), .converting_out(converting_out));
`default_nettype wire

// >>> test/bapcr_host_model.sv
// Host model: drives the serial clock, reads results
`timescale 1ns/100ps
`default_nettype none
module bapcr_host_model (
   input wire logic line_in,
   output var logic sclk_out
);
   initial sclk_out = 1'b0;
   // Clock n bits, sample before each next rise
   task automatic read_bits(input int n, output logic [18:0] bits);
      bits = 19'h0_0000;
      for (int k = 0; k < n; k++) begin
         sclk_out = 1'b1;
         #200;
         sclk_out = 1'b0;
         #200;
         bits = {bits[17:0], line_in};
      end
   endtask
   // Hold clock high for standby
   task automatic standby(input int ns);
      sclk_out = 1'b1;
      #(ns);
      sclk_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> test/tb_bapcr_top.sv
// Self-checking bench for the converter readout block
`timescale 1ns/100ps
`default_nettype none
module tb_bapcr_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic rate = 1'b0;
   logic pwr_n = 1'b1;
   logic ngnd = 1'b0;
   logic [23:0] filt = 24'h00_0000;
   wire logic sclk, line, oe, conv, sw;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   bapcr_top #(.LOW_CYCLES(400), .HIGH_CYCLES(200), .STANDBY_CYCLES(100)) u_dut (
      .sys_clk_in(clk), .nrst_in(nrst), .rate_select_in(rate), .power_off_n_in(pwr_n),
      .serial_clk_in(sclk), .negative_grounded_in(ngnd), .filter_data_in(filt),
      .ready_and_serial_out_out(line), .bridge_ground_switch_out(sw),
      .bridge_ground_switch_oe_out(oe), .converting_out(conv));
   bapcr_host_model u_host (.line_in(line), .sclk_out(sclk));
   // Clock and run limit
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk);
      #2;
   endtask
   // Bounded wait for a line level
   task automatic wait_line(input logic lvl, output int n);
      n = 0;
      while (line !== lvl && n < 1000) begin
         tick();
         n++;
      end
      check_count++;
      if (line !== lvl) begin
         err_total++;
         $display("BAD %0t line level never reached", $time);
      end
   endtask
   // One full read with a 19th clock
   task automatic t_read(input logic [23:0] f, input logic ng, input logic [17:0] code);
      logic [18:0] bits;
      int n;
      filt = f;
      ngnd = ng;
      wait_line(1'b0, n);
      u_host.read_bits(19, bits);
      check_count++;
      if (bits[18:1] !== code) begin
         err_total++;
         $display("BAD %0t code %h expected %h", $time, bits[18:1], code);
      end
      check_count++;
      if (bits[0] !== 1'b1) begin
         err_total++;
         $display("BAD %0t line not high after 19th clock", $time);
      end
   endtask
   // Power-off, rate choice, first result and pacing
   task automatic t_rate(input logic r);
      int n;
      pwr_n = 1'b0;
      repeat (6) tick();
      check_count++;
      if (line !== 1'b1 || oe !== 1'b0 || conv !== 1'b0) begin
         err_total++;
         $display("BAD %0t power-off state", $time);
      end
      rate = r;
      pwr_n = 1'b1;
      wait_line(1'b0, n);
      check_count++;
      if (n <= (r ? 198 : 398)) begin
         err_total++;
         $display("BAD %0t early result after %0d cycles", $time, n);
      end
      check_count++;
      if (oe !== 1'b1 || sw !== 1'b0) begin
         err_total++;
         $display("BAD %0t switch open while converting", $time);
      end
      wait_line(1'b1, n);
      check_count++;
      if (n !== (r ? 199 : 399)) begin
         err_total++;
         $display("BAD %0t rate period %0d cycles", $time, n);
      end
   endtask
   // Held clock enters standby, release wakes
   task automatic t_standby();
      fork
         u_host.standby(7000);
         begin
            repeat (90) tick();
            check_count++;
            if (conv !== 1'b1) begin
               err_total++;
               $display("BAD %0t standby entered too early", $time);
            end
            repeat (35) tick();
            check_count++;
            if (conv !== 1'b0 || oe !== 1'b0) begin
               err_total++;
               $display("BAD %0t no standby on held clock", $time);
            end
         end
      join
      repeat (6) tick();
      check_count++;
      if (conv !== 1'b1 || line !== 1'b1) begin
         err_total++;
         $display("BAD %0t no wake after standby", $time);
      end
   endtask
   // Main sequence
   initial begin
      repeat (4) tick();
      check_count++;
      if (line !== 1'b1 || conv !== 1'b0 || oe !== 1'b0) begin
         err_total++;
         $display("BAD %0t reset state", $time);
      end
      nrst = 1'b1;
      repeat (6) tick();
      check_count++;
      if (conv !== 1'b1 || oe !== 1'b1 || sw !== 1'b0 || line !== 1'b1) begin
         err_total++;
         $display("BAD %0t not active after reset", $time);
      end
      t_read(24'h00_1234, 1'b0, 18'h0_1234);
      t_read(24'h00_0000, 1'b0, 18'h0_0000);
      t_read(24'h7F_0000, 1'b0, 18'h1_FFFF);
      t_read(24'h80_0000, 1'b0, 18'h2_0000);
      t_read(24'hFF_FFFF, 1'b0, 18'h3_FFFF);
      t_read(24'hFF_FFFF, 1'b1, 18'h0_0000);
      t_read(24'h00_0100, 1'b1, 18'h0_0100);
      t_rate(1'b0);
      t_rate(1'b1);
      t_standby();
      stop_test();
   end
endmodule
`default_nettype wire
